/* File: core/tsm_pkg.sv */
// types and constants of the trigger sequencer and marker generator
package tsm_pkg;

	// ********************************************************
	// modes and states
	// ********************************************************
	typedef enum logic [2:0] {
		SEQ_CONTINUOUS       = 3'h0,
		SEQ_RESTART          = 3'h1,
		SEQ_ARMED_CONTINUOUS = 3'h2,
		SEQ_ARMED_RESTART    = 3'h3,
		SEQ_ONE_SHOT         = 3'h4
	} tsm_seq_mode_e;

	typedef enum logic [2:0] {
		MRK_LIST    = 3'h0,
		MRK_PULSE   = 3'h1,
		MRK_PATTERN = 3'h2,
		MRK_ON_OFF  = 3'h3,
		MRK_TRIGGER = 3'h4
	} tsm_mark_mode_e;

	typedef enum logic [1:0] {
		ST_WAIT  = 2'b00,
		ST_RUN   = 2'b01,
		ST_BURST = 2'b11
	} tsm_state_e;

	// ********************************************************
	// field widths and limits
	// ********************************************************
	localparam int DIV_W   = 11;
	localparam int PAT_W   = 32;
	localparam int PLEN_W  = 6;
	localparam int CNT_W   = 24;
	localparam int BURST_W = 32;
	localparam int DLY_W   = 16;
	localparam int INH_W   = 26;
	localparam int UPS_W   = 6;
	localparam int FILT_W  = 5;
	localparam int ROLL_W  = 7;

	localparam logic [DIV_W-1:0]   DIVISOR_MIN = 11'h002;
	localparam logic [DIV_W-1:0]   DIVISOR_MAX = 11'h400;
	localparam logic [DIV_W-1:0]   DIVISOR_RST = 11'h002;
	localparam logic [CNT_W-1:0]   COUNT_MIN   = 24'h000001;
	localparam logic [CNT_W-1:0]   COUNT_RST   = 24'h000001;
	localparam logic [PAT_W-1:0]   PATTERN_RST = 32'h00000001;
	localparam logic [PLEN_W-1:0]  PLEN_MIN    = 6'h01;
	localparam logic [PLEN_W-1:0]  PLEN_MAX    = 6'h20;
	localparam logic [PLEN_W-1:0]  PLEN_RST    = 6'h01;
	localparam logic [BURST_W-1:0] BURST_MIN   = 32'h00000001;
	localparam logic [BURST_W-1:0] BURST_RST   = 32'h000003e8;
	localparam logic [DLY_W-1:0]   DELAY_RST   = 16'h0000;
	localparam logic [INH_W-1:0]   INHIBIT_RST = 26'h0000000;
	localparam logic [UPS_W-1:0]   UPS_MIN     = 6'h01;
	localparam logic [UPS_W-1:0]   UPS_MAX     = 6'h20;
	localparam logic [UPS_W-1:0]   UPS_RST     = 6'h20;
	localparam logic [UPS_W-1:0]   UPS_AUTO    = 6'h20;
	localparam logic [FILT_W-1:0]  FILT_NBLMR  = 5'h09;
	localparam logic [ROLL_W-1:0]  ROLL_NBLMR  = 7'h14;

	// ********************************************************
	// per-marker settings
	// ********************************************************
	typedef struct packed {
		tsm_mark_mode_e    mode;
		logic [DIV_W-1:0]  divisor;
		logic [PAT_W-1:0]  pattern;
		logic [PLEN_W-1:0] patternLen;
		logic [CNT_W-1:0]  lowCount;
		logic [CNT_W-1:0]  highCount;
	} tsm_marker_cfg_s;

endpackage

/* File: core/tsm_trigger_marker.sv */
// trigger sequencer with per-marker generators and upsampling select
//
// Operation
// R1 - continuous mode runs without any trigger
// R2 - restart mode: every trigger restarts signal
// R3 - armed and one-shot modes wait for trigger
// R4 - armed continuous ignores triggers once running
// R5 - arm command stops armed modes, trigger restarts
// R6 - armed restart: later triggers each restart
// R7 - one-shot emits burst length symbols, stops
// R8 - one-shot: new trigger restarts the burst
// R9 - each marker has its own source selector
// R10 - list source follows control list marker
// R11 - pulse marker at symbol rate over divisor
// R12 - divisor 2 to 1024, reset value 2
// R13 - pattern up to 32 bits, sent serially
// R14 - pattern bit 0 inactive, 1 active
// R15 - on/off period is low plus high count
// R16 - low count 1 to 16777215, reset 1
// R17 - high count 1 to 16777215, reset 1
// R18 - upsampling factor 1 to 32, reset 32
// R19 - automatic upsampling chooses factor, else manual
// R20 - land-mobile filter select reloads its roll-off
// R21 - arm stops armed modes, next trigger restarts
// R22 - burst length 1 to 4294967295, reset 1000
// R23 - external trigger delayed 0 to 65535 symbols
// R24 - external restart inhibited for programmed symbols
// R25 - reset: continuous mode, markers on/off source
// R26 - pattern repeats, restarts at generation start
`timescale 1ns/100ps
`default_nettype none

module tsm_trigger_marker
	import tsm_pkg::*;
#(
	parameter int NUM_MARKERS = 4
) (
	input  wire logic                                        ref_clk,
	input  wire logic                                        reset,
	input  wire logic                                        symStrobe,
	input  wire logic [31:0]                                 symRateHz,
	input  wire logic                                        seqLoad,
	input  wire tsm_pkg::tsm_seq_mode_e                      seqMode,
	input  wire logic                                        trigLoad,
	input  wire logic                                        trigSourceExt,
	input  wire logic [tsm_pkg::BURST_W-1:0]                 burstSymbolCount,
	input  wire logic [tsm_pkg::DLY_W-1:0]                   extDelay,
	input  wire logic [tsm_pkg::INH_W-1:0]                   extInhibit,
	input  wire logic                                        intTrigger,
	input  wire logic                                        extTriggerPin,
	input  wire logic                                        armCmd,
	input  wire logic [NUM_MARKERS-1:0]                      markerLoad,
	input  wire tsm_pkg::tsm_marker_cfg_s [NUM_MARKERS-1:0]  markerCfg,
	input  wire logic [NUM_MARKERS-1:0]                      listMarker,
	input  wire logic                                        filterLoad,
	input  wire logic                                        upsampleAuto,
	input  wire logic [tsm_pkg::UPS_W-1:0]                   upsampleManual,
	input  wire logic [tsm_pkg::FILT_W-1:0]                  filterType,
	input  wire logic [tsm_pkg::ROLL_W-1:0]                  rolloffValue,
	output logic                                             genEnable,
	output logic                                             restartPulse,
	output logic [NUM_MARKERS-1:0]                           markerOut,
	output logic [NUM_MARKERS-1:0][31:0]                     pulseFreqHz,
	output logic [tsm_pkg::UPS_W-1:0]                        upsampleFactor,
	output logic [tsm_pkg::FILT_W-1:0]                       filterSel,
	output logic [tsm_pkg::ROLL_W-1:0]                       rolloff
);
	import tsm_pkg::*;

	// ********************************************************
	// sequencer settings
	// ********************************************************
	tsm_seq_mode_e      mode_q;
	logic               srcExt_q;
	logic [BURST_W-1:0] burstLen_q;
	logic [DLY_W-1:0]   delay_q;
	logic [INH_W-1:0]   inhibit_q;
	logic               modeChange_q;

	// R25 reset to continuous; R22 burst length clamp
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mode_q     <= SEQ_CONTINUOUS;
			srcExt_q   <= 1'b0;
			burstLen_q <= BURST_RST;
			delay_q    <= DELAY_RST;
			inhibit_q  <= INHIBIT_RST;
		end else begin
			if (seqLoad) begin
				mode_q <= seqMode;
			end
			if (trigLoad) begin
				srcExt_q   <= trigSourceExt;
				burstLen_q <= (burstSymbolCount < BURST_MIN) ?
					BURST_MIN : burstSymbolCount;
				delay_q    <= extDelay;
				inhibit_q  <= extInhibit;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			modeChange_q <= 1'b0;
		end else begin
			modeChange_q <= seqLoad;
		end
	end

	// ********************************************************
	// external trigger: sync, delay, inhibit
	// ********************************************************
	logic             extMeta_q;
	logic             extSync_q;
	logic             extPrev_q;
	logic             pending_q;
	logic [DLY_W-1:0] delayCnt_q;
	logic [INH_W-1:0] inhibitCnt_q;
	logic             extEdge;
	logic             extFire;
	logic             trigEvent;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			extMeta_q <= 1'b0;
			extSync_q <= 1'b0;
			extPrev_q <= 1'b0;
		end else begin
			extMeta_q <= extTriggerPin;
			extSync_q <= extMeta_q;
			extPrev_q <= extSync_q;
		end
	end

	// R24 edges ignored while inhibit runs
	assign extEdge = extSync_q & ~extPrev_q & srcExt_q & ~pending_q &
		(inhibitCnt_q == '0);
	assign extFire = pending_q & (delayCnt_q == '0);
	assign trigEvent = srcExt_q ? extFire : intTrigger;

	// R23 delay counted in symbols
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pending_q  <= 1'b0;
			delayCnt_q <= '0;
		end else if (extEdge) begin
			pending_q  <= 1'b1;
			delayCnt_q <= delay_q;
		end else if (extFire) begin
			pending_q <= 1'b0;
		end else if (pending_q && symStrobe) begin
			delayCnt_q <= delayCnt_q - 1'b1;
		end
	end

	// R24 inhibit reloads on each accepted trigger
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			inhibitCnt_q <= '0;
		end else if (extFire) begin
			inhibitCnt_q <= inhibit_q;
		end else if (symStrobe && inhibitCnt_q != '0) begin
			inhibitCnt_q <= inhibitCnt_q - 1'b1;
		end
	end

	// ********************************************************
	// sequencer state machine
	// ********************************************************
	tsm_state_e         state_q;
	logic [BURST_W-1:0] burstCnt_q;
	logic               isArmed;

	assign isArmed = (mode_q == SEQ_ARMED_CONTINUOUS) ||
		(mode_q == SEQ_ARMED_RESTART);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q      <= ST_RUN;
			burstCnt_q   <= '0;
			restartPulse <= 1'b0;
		end else begin
			restartPulse <= 1'b0;
			if (modeChange_q) begin
				// R1 continuous and restart modes start at once
				if (mode_q == SEQ_CONTINUOUS || mode_q == SEQ_RESTART) begin
					state_q      <= ST_RUN;
					restartPulse <= 1'b1;
				end else begin
					// R3 wait for trigger
					state_q <= ST_WAIT;
				end
			end else if (armCmd && isArmed) begin
				// R5 R21 arm stops generation
				state_q <= ST_WAIT;
			end else begin
				case (mode_q)
					SEQ_CONTINUOUS: begin
						state_q <= ST_RUN;
					end
					// R2 restart on every trigger
					SEQ_RESTART: begin
						state_q      <= ST_RUN;
						restartPulse <= trigEvent;
					end
					// R4 triggers ignored once running
					SEQ_ARMED_CONTINUOUS: begin
						if (trigEvent && state_q == ST_WAIT) begin
							state_q      <= ST_RUN;
							restartPulse <= 1'b1;
						end
					end
					// R6 start, then every trigger restarts
					SEQ_ARMED_RESTART: begin
						if (trigEvent) begin
							state_q      <= ST_RUN;
							restartPulse <= 1'b1;
						end
					end
					SEQ_ONE_SHOT: begin
						// R8 trigger reloads the burst
						if (trigEvent) begin
							state_q      <= ST_BURST;
							burstCnt_q   <= burstLen_q;
							restartPulse <= 1'b1;
						end else if (state_q == ST_BURST && symStrobe) begin
							// R7 stop after the last symbol
							burstCnt_q <= burstCnt_q - 1'b1;
							if (burstCnt_q == BURST_MIN) begin
								state_q <= ST_WAIT;
							end
						end
					end
					default: begin
						state_q <= ST_WAIT;
					end
				endcase
			end
		end
	end

	assign genEnable = (state_q != ST_WAIT);

	// R7 burst ends exactly when count runs out
	a_burst_stop: assert property (@(posedge ref_clk) // R7
		disable iff (reset)
		(state_q == ST_BURST && symStrobe && burstCnt_q == BURST_MIN &&
		!trigEvent && !modeChange_q && mode_q == SEQ_ONE_SHOT)
		|=> state_q == ST_WAIT)
		else $error("burst did not stop at its last symbol");

	// R4 running armed continuous never restarts
	a_armed_no_restart: assert property (@(posedge ref_clk) // R4
		disable iff (reset)
		(mode_q == SEQ_ARMED_CONTINUOUS && state_q == ST_RUN &&
		!modeChange_q && !armCmd) |=> !restartPulse)
		else $error("armed continuous restarted while running");

	// R5 arm stops armed generation
	a_arm_stops: assert property (@(posedge ref_clk) // R5
		disable iff (reset)
		(armCmd && isArmed && !modeChange_q && !seqLoad)
		|=> !genEnable)
		else $error("arm command did not stop generation");

	// R2 trigger in restart mode restarts
	a_restart_trig: assert property (@(posedge ref_clk) // R2
		disable iff (reset)
		(mode_q == SEQ_RESTART && trigEvent && !modeChange_q && !armCmd)
		|=> restartPulse && genEnable)
		else $error("trigger did not restart the signal");

	// R1 continuous mode keeps generating
	a_cont_runs: assert property (@(posedge ref_clk) // R1
		disable iff (reset)
		(mode_q == SEQ_CONTINUOUS && !seqLoad)[*2] |-> genEnable)
		else $error("continuous mode not generating");

	// R23 zero-delay external fire follows the edge by one cycle
	a_ext_delay: assert property (@(posedge ref_clk) // R23
		disable iff (reset)
		(extEdge && delay_q == '0 && !trigLoad) |=> extFire)
		else $error("zero delay trigger did not fire next cycle");

	// ********************************************************
	// marker generators
	// ********************************************************
	genvar m;
	generate
		for (m = 0; m < NUM_MARKERS; m++) begin : gMarker
			tsm_marker_cfg_s    cfg_q;
			logic [DIV_W-1:0]   divCnt_q;
			logic [PLEN_W-1:0]  patIdx_q;
			logic [CNT_W-1:0]   ratioCnt_q;
			logic               ratioHigh_q;
			logic               trigMark_q;
			logic               mark;
			logic [DIV_W-1:0]   halfDiv;
			logic [PLEN_W-1:0]  bitSel;

			// R9 R12 R16 R17 R13 settings clamped on load; R25 on/off
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					cfg_q.mode       <= MRK_ON_OFF;
					cfg_q.divisor    <= DIVISOR_RST;
					cfg_q.pattern    <= PATTERN_RST;
					cfg_q.patternLen <= PLEN_RST;
					cfg_q.lowCount   <= COUNT_RST;
					cfg_q.highCount  <= COUNT_RST;
				end else if (markerLoad[m]) begin
					cfg_q.mode    <= markerCfg[m].mode;
					cfg_q.pattern <= markerCfg[m].pattern;
					cfg_q.divisor <=
						(markerCfg[m].divisor < DIVISOR_MIN) ? DIVISOR_MIN :
						(markerCfg[m].divisor > DIVISOR_MAX) ? DIVISOR_MAX :
						markerCfg[m].divisor;
					cfg_q.patternLen <=
						(markerCfg[m].patternLen < PLEN_MIN) ? PLEN_MIN :
						(markerCfg[m].patternLen > PLEN_MAX) ? PLEN_MAX :
						markerCfg[m].patternLen;
					cfg_q.lowCount <= (markerCfg[m].lowCount < COUNT_MIN) ?
						COUNT_MIN : markerCfg[m].lowCount;
					cfg_q.highCount <= (markerCfg[m].highCount < COUNT_MIN) ?
						COUNT_MIN : markerCfg[m].highCount;
				end
			end

			// R11 pulse counter; R26 R15 restart from the first symbol
			always_ff @(posedge ref_clk) begin
				if (reset || restartPulse || !genEnable) begin
					divCnt_q    <= '0;
					patIdx_q    <= '0;
					ratioCnt_q  <= '0;
					ratioHigh_q <= 1'b1;
				end else if (symStrobe) begin
					divCnt_q <= (divCnt_q >= cfg_q.divisor - 1'b1) ?
						'0 : divCnt_q + 1'b1;
					patIdx_q <= (patIdx_q >= cfg_q.patternLen - 1'b1) ?
						'0 : patIdx_q + 1'b1;
					if (ratioCnt_q >= (ratioHigh_q ? cfg_q.highCount :
						cfg_q.lowCount) - 1'b1) begin
						ratioCnt_q  <= '0;
						ratioHigh_q <= ~ratioHigh_q;
					end else begin
						ratioCnt_q <= ratioCnt_q + 1'b1;
					end
				end
			end

			// one symbol of marker after each restart
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					trigMark_q <= 1'b0;
				end else if (restartPulse) begin
					trigMark_q <= 1'b1;
				end else if (symStrobe) begin
					trigMark_q <= 1'b0;
				end
			end

			// R11 frequency reported; divide kept off the marker path
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					pulseFreqHz[m] <= 32'h00000000;
				end else begin
					pulseFreqHz[m] <= symRateHz / 32'(cfg_q.divisor);
				end
			end

			assign halfDiv = cfg_q.divisor >> 1;
			// first pattern bit is the most significant of the length
			assign bitSel = cfg_q.patternLen - 1'b1 - patIdx_q;

			// R9 R10 R14 source selector
			always_comb begin
				mark = 1'b0;
				case (cfg_q.mode)
					MRK_LIST:    mark = listMarker[m];
					MRK_PULSE:   mark = genEnable && (divCnt_q < halfDiv);
					MRK_PATTERN: mark = genEnable &&
						cfg_q.pattern[bitSel[4:0]];
					MRK_ON_OFF:  mark = genEnable && ratioHigh_q;
					MRK_TRIGGER: mark = trigMark_q;
					default:     mark = 1'b0;
				endcase
			end

			always_ff @(posedge ref_clk) begin
				if (reset) begin
					markerOut[m] <= 1'b0;
				end else begin
					markerOut[m] <= mark;
				end
			end

			// R12 divisor held inside its range
			a_div_range: assert property (@(posedge ref_clk) // R12
				disable iff (reset)
				cfg_q.divisor >= DIVISOR_MIN &&
				cfg_q.divisor <= DIVISOR_MAX)
				else $error("pulse divisor out of range");

			// R15 high phase starts from a zero count
			a_on_off_marker_phase: assert property (@(posedge ref_clk) // R15
				disable iff (reset)
				(ratioHigh_q && !$past(ratioHigh_q) && genEnable)
				|-> ratioCnt_q == '0)
				else $error("on phase did not start from zero");

			// R10 list source passes through
			a_list_follow: assert property (@(posedge ref_clk) // R10
				disable iff (reset)
				(cfg_q.mode == MRK_LIST && !markerLoad[m])
				|=> markerOut[m] == $past(listMarker[m]))
				else $error("list marker not followed");
		end
	endgenerate

	// ********************************************************
	// filter upsampling and roll-off
	// ********************************************************
	logic             upsAuto_q;
	logic [UPS_W-1:0] upsManual_q;

	// R18 manual factor clamped
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			upsAuto_q   <= 1'b1;
			upsManual_q <= UPS_RST;
			filterSel   <= '0;
			rolloff     <= ROLL_NBLMR;
		end else if (filterLoad) begin
			upsAuto_q   <= upsampleAuto;
			upsManual_q <= (upsampleManual < UPS_MIN) ? UPS_MIN :
				(upsampleManual > UPS_MAX) ? UPS_MAX : upsampleManual;
			filterSel   <= filterType;
			// R20 selecting the land-mobile filter reloads roll-off
			rolloff <= (filterType == FILT_NBLMR) ? ROLL_NBLMR : rolloffValue;
		end
	end

	// R19 automatic choice overrides the manual factor
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			upsampleFactor <= UPS_RST;
		end else begin
			upsampleFactor <= upsAuto_q ? UPS_AUTO : upsManual_q;
		end
	end

	// R20 roll-off default after land-mobile select
	a_nblmr_roll: assert property (@(posedge ref_clk) // R20
		disable iff (reset)
		(filterLoad && filterType == FILT_NBLMR) |=> rolloff == ROLL_NBLMR)
		else $error("land-mobile roll-off not reloaded");

endmodule

`default_nettype wire

/* File: tb/tsm_far_side.sv */
// external trigger source standing at the block's trigger pin
`timescale 1ns/100ps
`default_nettype none

module tsm_far_side (
	input  wire logic ref_clk,
	output logic      extTriggerPin
);
	// ****************************************
	// trigger source
	// ****************************************
	// pin idles low; a long high keeps the edge clear of the synchroniser
	initial begin
		extTriggerPin = 1'b0;
	end

	task automatic fire;
		@(posedge ref_clk) extTriggerPin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		extTriggerPin <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
endmodule

`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench of the trigger sequencer and marker generator
`timescale 1ns/100ps
`default_nettype none

module tb;
	import tsm_pkg::*;
	// ****************************************
	// stimulus and observation
	// ****************************************
	logic ref_clk, reset, symStrobe, seqLoad, trigLoad, trigSourceExt;
	logic intTrigger, armCmd, filterLoad, upsampleAuto, genEnable;
	logic restartPulse, extTriggerPin;
	logic [31:0] symRateHz, burstSymbolCount;
	tsm_seq_mode_e seqMode;
	logic [DLY_W-1:0] extDelay;
	logic [INH_W-1:0] extInhibit;
	logic [3:0] markerLoad, listMarker, markerOut;
	tsm_marker_cfg_s [3:0] markerCfg;
	logic [3:0][31:0] pulseFreqHz;
	logic [UPS_W-1:0] upsampleManual, upsampleFactor;
	logic [FILT_W-1:0] filterType, filterSel;
	logic [ROLL_W-1:0] rolloffValue, rolloff;
	int miscompares = 0;
	int comparisons = 0;
	int rsCount = 0;
	int r0;

	tsm_trigger_marker #(.NUM_MARKERS(4)) i_dut (
		.ref_clk(ref_clk), .reset(reset), .symStrobe(symStrobe),
		.symRateHz(symRateHz), .seqLoad(seqLoad), .seqMode(seqMode),
		.trigLoad(trigLoad), .trigSourceExt(trigSourceExt),
		.burstSymbolCount(burstSymbolCount), .extDelay(extDelay),
		.extInhibit(extInhibit), .intTrigger(intTrigger),
		.extTriggerPin(extTriggerPin), .armCmd(armCmd),
		.markerLoad(markerLoad), .markerCfg(markerCfg),
		.listMarker(listMarker), .filterLoad(filterLoad),
		.upsampleAuto(upsampleAuto), .upsampleManual(upsampleManual),
		.filterType(filterType), .rolloffValue(rolloffValue),
		.genEnable(genEnable), .restartPulse(restartPulse),
		.markerOut(markerOut), .pulseFreqHz(pulseFreqHz),
		.upsampleFactor(upsampleFactor), .filterSel(filterSel),
		.rolloff(rolloff));

	tsm_far_side i_far (.ref_clk(ref_clk), .extTriggerPin(extTriggerPin));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// restarts are counted so a one-cycle pulse is never missed
	always @(posedge ref_clk) begin
		if (restartPulse === 1'b1)
			rsCount++;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic sym;
		@(posedge ref_clk) symStrobe <= 1'b1;
		@(posedge ref_clk) symStrobe <= 1'b0;
	endtask

	task automatic set_mode(input tsm_seq_mode_e m);
		@(posedge ref_clk) begin
			seqMode <= m;
			seqLoad <= 1'b1;
		end
		@(posedge ref_clk) seqLoad <= 1'b0;
		step(3);
	endtask

	task automatic trig;
		@(posedge ref_clk) intTrigger <= 1'b1;
		@(posedge ref_clk) intTrigger <= 1'b0;
		step(2);
	endtask

	task automatic arm;
		@(posedge ref_clk) armCmd <= 1'b1;
		@(posedge ref_clk) armCmd <= 1'b0;
		step(2);
	endtask

	task automatic set_trig(input logic e, input logic [31:0] len,
			input logic [DLY_W-1:0] d, input logic [INH_W-1:0] h);
		@(posedge ref_clk) begin
			trigSourceExt <= e;
			burstSymbolCount <= len;
			extDelay <= d;
			extInhibit <= h;
			trigLoad <= 1'b1;
		end
		@(posedge ref_clk) trigLoad <= 1'b0;
		step(1);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic test_modes;
		chk(genEnable, 1);
		trig();
		chk(genEnable, 1);
		set_mode(SEQ_RESTART);
		r0 = rsCount;
		trig();
		chk(rsCount - r0, 1);
		set_mode(SEQ_ARMED_CONTINUOUS);
		chk(genEnable, 0);
		r0 = rsCount;
		trig();
		chk(genEnable, 1);
		trig();
		chk(rsCount - r0, 1);
		arm();
		chk(genEnable, 0);
		trig();
		chk(genEnable, 1);
		set_mode(SEQ_ARMED_RESTART);
		chk(genEnable, 0);
		r0 = rsCount;
		trig();
		trig();
		chk(rsCount - r0, 2);
		arm();
		chk(genEnable, 0);
	endtask

	task automatic test_burst;
		set_trig(1'b0, 32'h00000003, 16'h0000, 26'h0000000);
		set_mode(SEQ_ONE_SHOT);
		chk(genEnable, 0);
		trig();
		sym();
		sym();
		step(2);
		chk(genEnable, 1);
		trig();
		sym();
		sym();
		step(2);
		chk(genEnable, 1);
		sym();
		step(2);
		chk(genEnable, 0);
	endtask

	task automatic test_markers;
		logic [3:0] pat;
		pat = 4'hb;
		@(posedge ref_clk) begin
			markerCfg[0] <= '{MRK_PATTERN, 11'h002, 32'h0000000b, 6'h04,
				24'h000001, 24'h000001};
			markerCfg[2] <= '{MRK_ON_OFF, 11'h002, 32'h00000001, 6'h01,
				24'h000002, 24'h000001};
			markerCfg[3] <= '{MRK_LIST, 11'h002, 32'h00000001, 6'h01,
				24'h000001, 24'h000001};
			markerLoad <= 4'b1101;
		end
		@(posedge ref_clk) markerLoad <= 4'b0000;
		set_mode(SEQ_CONTINUOUS);
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk) listMarker <= {i[0], 3'b000};
			step(2);
			chk(markerOut[0], pat[3 - (i % 4)]);
			chk(markerOut[1], !i[0]);
			chk(markerOut[2], (i % 3) == 0);
			chk(markerOut[3], i[0]);
			sym();
		end
	endtask

	task automatic test_pulse;
		logic [10:0] dv [4] = '{11'h004, 11'h001, 11'h400, 11'h7ff};
		logic [31:0] ex [4] = '{32'h00040000, 32'h00080000,
			32'h00000400, 32'h00000400};
		chk(pulseFreqHz[1], 32'h00080000);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk) begin
				markerCfg[1] <= '{MRK_PULSE, dv[i], 32'h00000001, 6'h01,
					24'h000001, 24'h000001};
				markerLoad <= 4'b0010;
			end
			@(posedge ref_clk) markerLoad <= 4'b0000;
			step(3);
			chk(pulseFreqHz[1], ex[i]);
		end
		// restart lines up the divider and the one-symbol trigger marker
		@(posedge ref_clk) begin
			markerCfg[0] <= '{MRK_TRIGGER, 11'h002, 32'h00000001, 6'h01,
				24'h000001, 24'h000001};
			markerCfg[1] <= '{MRK_PULSE, 11'h004, 32'h00000001, 6'h01,
				24'h000001, 24'h000001};
			markerLoad <= 4'b0011;
		end
		@(posedge ref_clk) markerLoad <= 4'b0000;
		set_mode(SEQ_CONTINUOUS);
		for (int i = 0; i < 6; i++) begin
			step(2);
			chk(markerOut[0], i == 0);
			chk(markerOut[1], (i % 4) < 2);
			sym();
		end
	endtask

	task automatic test_filter;
		logic [6:0] ra [4] = '{7'h32, 7'h32, 7'h32, 7'h32};
		logic [5:0] mn [4] = '{6'h05, 6'h00, 6'h05, 6'h21};
		logic au [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
		logic [4:0] ty [4] = '{5'h03, 5'h09, 5'h03, 5'h09};
		logic [5:0] eu [4] = '{6'h05, 6'h01, 6'h20, 6'h20};
		logic [6:0] er [4] = '{7'h32, 7'h14, 7'h32, 7'h14};
		chk(upsampleFactor, 32'h20);
		chk(rolloff, 32'h14);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk) begin
				upsampleAuto <= au[i];
				upsampleManual <= mn[i];
				filterType <= ty[i];
				rolloffValue <= ra[i];
				filterLoad <= 1'b1;
			end
			@(posedge ref_clk) filterLoad <= 1'b0;
			step(2);
			chk(upsampleFactor, eu[i]);
			chk(filterSel, ty[i]);
			chk(rolloff, er[i]);
		end
	endtask

	task automatic test_ext;
		set_trig(1'b1, 32'h000003e8, 16'h0002, 26'h0000000);
		set_mode(SEQ_RESTART);
		r0 = rsCount;
		i_far.fire();
		chk(rsCount - r0, 0);
		sym();
		step(2);
		chk(rsCount - r0, 0);
		sym();
		step(3);
		chk(rsCount - r0, 1);
		set_trig(1'b1, 32'h000003e8, 16'h0000, 26'h0000003);
		r0 = rsCount;
		i_far.fire();
		i_far.fire();
		chk(rsCount - r0, 1);
		repeat (3) sym();
		i_far.fire();
		chk(rsCount - r0, 2);
	endtask

	// ****************************************
	// run control
	// ****************************************
	task automatic tally_and_finish;
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		tally_and_finish();
	end

	initial begin
		reset = 1'b1;
		symStrobe = 1'b0;
		symRateHz = 32'h00100000;
		seqLoad = 1'b0;
		seqMode = SEQ_CONTINUOUS;
		trigLoad = 1'b0;
		trigSourceExt = 1'b0;
		burstSymbolCount = 32'h000003e8;
		extDelay = 16'h0000;
		extInhibit = 26'h0000000;
		intTrigger = 1'b0;
		armCmd = 1'b0;
		markerLoad = 4'b0000;
		markerCfg = '0;
		listMarker = 4'b0000;
		filterLoad = 1'b0;
		upsampleAuto = 1'b1;
		upsampleManual = 6'h20;
		filterType = 5'h00;
		rolloffValue = 7'h14;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		step(1);
		test_filter();
		test_modes();
		test_burst();
		test_markers();
		test_pulse();
		test_ext();
		tally_and_finish();
	end
endmodule

`default_nettype wire
